//--- include/eep_pkg.sv
// Constants and types for the two-wire memory slave port.
// Notes on behaviour
// - Sample on clock rise, drive on fall.
// - Lock pin high makes whole array read-only.
// - Lock pin high: address bytes acked, data not.
// - Lock pin low permits writes unless soft-locked.
// - Array is 128 pages of 16 bytes.
// - Byte and partial or full page writes.
// - Self-timed programming, at most 3 ms.
// - Sixteen byte id page, lockable until reset.
// - Read-only 128-bit unique id, dedicated read.
// - Soft lock bit blocks all array writes.
// - Programming starts only on stop after write.
// - Bytes MSB first, ninth clock for acknowledge.
// - Address nack returns to idle until start.
package eep_pkg;
   localparam int unsigned PAGE_BYTES = 16;
   localparam int unsigned PAGES = 128;
   localparam int unsigned MEM_BYTES = PAGES * PAGE_BYTES;
   localparam int unsigned FIFO_DEPTH = 8;
   localparam int unsigned DATA_W = 8;
   localparam logic [3:0] TYPE_MEM = 4'ha;
   localparam logic [3:0] TYPE_AUX = 4'hb;
   localparam logic [3:0] CNT_ACK = 4'h8;
   localparam logic [3:0] CNT_END = 4'h9;
   localparam int unsigned PROG_TIME_NS = 3000000;
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned PROG_CYCLES_DEF = PROG_TIME_NS / CLK_PERIOD_NS;
   // Value is arbitrary.
   localparam logic [127:0] UID_DEF = 128'h5a3c_96e1_0f2d_4b78_c3a5_1e69_d287_f04b;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_DEV = 3'b001,
      ST_ADDR = 3'b010,
      ST_WRITE = 3'b011,
      ST_READ = 3'b100
   } eep_state_e;
   typedef enum logic [2:0] {
      FN_MEM = 3'b000,
      FN_ID = 3'b001,
      FN_LOCK = 3'b010,
      FN_SOFT = 3'b011,
      FN_UID = 3'b100
   } eep_fn_e;
endpackage

//--- include/eep_fifo_if.sv
// Valid and ready carrier between the serial engine and its byte FIFO.
interface eep_fifo_if #(parameter int unsigned W = 8);
   logic in_valid;
   logic in_ready;
   logic [W-1:0] in_data;
   logic out_valid;
   logic out_ready;
   logic [W-1:0] out_data;
   modport user (output in_valid, output in_data, input in_ready,
      input out_valid, input out_data, output out_ready);
   modport store (input in_valid, input in_data, output in_ready,
      output out_valid, output out_data, input out_ready);
endinterface

//--- hdl/eep_fifo.sv
// Byte FIFO between the serial receiver and the page buffer loader.
module eep_fifo #(
   parameter int unsigned W = 8,
   parameter int unsigned DEPTH = 8
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic reset,
   // Both sides.
   eep_fifo_if.store bus
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;
   logic full;
   logic empty;
   assign empty = (wr_ptr == rd_ptr);
   assign full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
   assign bus.in_ready = ~full;
   assign bus.out_valid = ~empty;
   assign bus.out_data = mem[rd_ptr[AW-1:0]];
   always_ff @(posedge core_clk) begin
      if (bus.in_valid && !full) begin
         mem[wr_ptr[AW-1:0]] <= bus.in_data;
      end
   end
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (bus.in_valid && !full) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (bus.out_ready && !empty) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule

//--- hdl/eep_slave_port.sv
// Two-wire serial memory slave: bus engine, page buffer, programming timer and storage.
module eep_slave_port #(
   parameter int unsigned PROG_CYCLES = eep_pkg::PROG_CYCLES_DEF,
   parameter logic [127:0] UID = eep_pkg::UID_DEF
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic reset,
   // Two-wire bus pins.
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Array lock pin.
   input wire logic array_lock,
   // Status.
   output logic prog_busy
);
   import eep_pkg::*;

   eep_fifo_if #(.W(DATA_W)) fq ();
   eep_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .core_clk(core_clk),
      .reset(reset),
      .bus(fq.store)
   );

   logic [2:0] scl_p;
   logic [2:0] sda_p;
   logic [1:0] lock_p;
   eep_state_e state;
   eep_fn_e fn;
   logic [3:0] cnt;
   logic [7:0] shreg;
   logic is_read;
   logic [10:0] addr;
   logic wr_seen;
   logic [31:0] prog_cnt;
   logic [7:0] page_buf [PAGE_BYTES];
   logic [PAGE_BYTES-1:0] mask;
   logic [3:0] ld_ptr;
   logic [10:0] wr_base;
   eep_fn_e wr_fn;
   logic [7:0] mem [MEM_BYTES];
   logic [7:0] id_page [PAGE_BYTES];
   logic id_lock;
   logic soft_lock_bit;
   logic [7:0] rd_byte;

   // Both bus lines are sampled through two flops; the third stage only feeds edge detection.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         scl_p <= 3'h7;
         sda_p <= 3'h7;
         lock_p <= 2'h0;
      end else begin
         scl_p <= {scl_p[1:0], scl};
         sda_p <= {sda_p[1:0], sda_in};
         lock_p <= {lock_p[0], array_lock};
      end
   end

   wire scl_rise = scl_p[1] & ~scl_p[2];
   wire scl_fall = ~scl_p[1] & scl_p[2];
   wire bus_start = scl_p[1] & scl_p[2] & sda_p[2] & ~sda_p[1];
   wire bus_stop = scl_p[1] & scl_p[2] & ~sda_p[2] & sda_p[1];
   wire hw_lock = lock_p[1];
   wire active = (state != ST_IDLE) && !bus_start && !bus_stop;
   wire ack_slot = active && scl_fall && (cnt == CNT_ACK);
   wire dev_hit = (shreg[7:4] == TYPE_MEM || shreg[7:4] == TYPE_AUX) && !prog_busy;

   // Soft lock stays writable under its own bit so it can be cleared again.
   wire blocked = hw_lock
      | (soft_lock_bit && (fn == FN_MEM || fn == FN_ID))
      | (id_lock && (fn == FN_ID || fn == FN_LOCK))
      | (fn == FN_UID);

   wire push = ack_slot && (state == ST_WRITE) && !blocked && fq.in_ready;
   wire addr_take = ack_slot && (state == ST_ADDR);
   wire prog_done = prog_busy && (prog_cnt == PROG_CYCLES - 1);

   assign fq.in_valid = push;
   assign fq.in_data = shreg;
   // The loader stalls while a page is being programmed.
   assign fq.out_ready = ~prog_busy;

   always_comb begin
      unique case (fn)
         FN_MEM: rd_byte = mem[addr];
         FN_ID: rd_byte = id_page[addr[3:0]];
         FN_LOCK: rd_byte = {7'h00, id_lock};
         FN_SOFT: rd_byte = {7'h00, soft_lock_bit};
         FN_UID: rd_byte = UID[{~addr[3:0], 3'b111} -: 8];
         default: rd_byte = 8'hff;
      endcase
   end

   // Bus engine: bits in on rise, SDA changes only on fall.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         state <= ST_IDLE;
         cnt <= 4'h0;
         shreg <= 8'h00;
         sda_oe <= 1'b0;
         is_read <= 1'b0;
         fn <= FN_MEM;
         addr <= 11'h000;
      end else if (bus_start) begin
         state <= ST_DEV;
         cnt <= 4'h0;
         sda_oe <= 1'b0;
      end else if (bus_stop) begin
         state <= ST_IDLE;
         cnt <= 4'h0;
         sda_oe <= 1'b0;
      end else if (state != ST_IDLE) begin
         if (scl_rise) begin
            cnt <= cnt + 4'h1;
            if (cnt < CNT_ACK) begin
               shreg <= {shreg[6:0], sda_p[1]};
            end else if (state == ST_READ) begin
               if (sda_p[1]) begin
                  state <= ST_IDLE;
               end else if (fn == FN_MEM) begin
                  addr <= addr + 11'h001;
               end else begin
                  addr <= {addr[10:4], addr[3:0] + 4'h1};
               end
            end
         end else if (scl_fall) begin
            if (cnt == CNT_ACK) begin
               unique case (state)
                  ST_DEV: begin
                     sda_oe <= dev_hit;
                     is_read <= shreg[0];
                     if (dev_hit && shreg[7:4] == TYPE_MEM) begin
                        fn <= FN_MEM;
                        addr[10:8] <= shreg[3:1];
                     end else if (dev_hit && fn == FN_MEM) begin
                        // An aux access must not inherit the memory function of the last one.
                        fn <= FN_ID;
                     end
                  end
                  ST_ADDR: begin
                     sda_oe <= 1'b1;
                     if (fn == FN_MEM) begin
                        addr[7:0] <= shreg;
                     end else begin
                        fn <= eep_fn_e'({1'b0, shreg[7:6]} + 3'h1);
                        addr[3:0] <= shreg[3:0];
                     end
                  end
                  ST_WRITE: sda_oe <= push;
                  ST_READ: sda_oe <= 1'b0;
               endcase
            end else if (cnt == CNT_END) begin
               cnt <= 4'h0;
               sda_oe <= 1'b0;
               unique case (state)
                  ST_DEV: begin
                     if (!sda_oe) begin
                        state <= ST_IDLE;
                     end else if (is_read) begin
                        state <= ST_READ;
                        sda_oe <= ~rd_byte[7];
                     end else begin
                        state <= ST_ADDR;
                     end
                  end
                  ST_ADDR: state <= ST_WRITE;
                  ST_WRITE: begin
                     if (!sda_oe) begin
                        state <= ST_IDLE;
                     end
                  end
                  ST_READ: sda_oe <= ~rd_byte[7];
               endcase
            end else if (state == ST_READ) begin
               sda_oe <= ~rd_byte[3'(4'h7 - cnt)];
            end
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end

   // Page buffer loader fed from the FIFO.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         mask <= '0;
         ld_ptr <= 4'h0;
         wr_base <= 11'h000;
         wr_fn <= FN_MEM;
      end else if (addr_take) begin
         mask <= '0;
         ld_ptr <= shreg[3:0];
         wr_base <= (fn == FN_MEM) ? {addr[10:8], shreg} : {7'h00, shreg[3:0]};
         wr_fn <= (fn == FN_MEM) ? FN_MEM : eep_fn_e'({1'b0, shreg[7:6]} + 3'h1);
      end else if (prog_done) begin
         mask <= '0;
      end else if (fq.out_valid && fq.out_ready) begin
         mask[ld_ptr] <= 1'b1;
         ld_ptr <= ld_ptr + 4'h1;
      end
   end

   always_ff @(posedge core_clk) begin
      if (fq.out_valid && fq.out_ready) begin
         page_buf[ld_ptr] <= fq.out_data;
      end
   end

   // Programming timer; a stop after accepted data starts it.
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         prog_busy <= 1'b0;
         prog_cnt <= 32'h0000_0000;
         wr_seen <= 1'b0;
      end else begin
         if (bus_start) begin
            wr_seen <= 1'b0;
         end else if (push) begin
            wr_seen <= 1'b1;
         end
         if (!prog_busy) begin
            if (bus_stop && state == ST_WRITE && wr_seen) begin
               prog_busy <= 1'b1;
               prog_cnt <= 32'h0000_0000;
            end
         end else if (prog_done) begin
            prog_busy <= 1'b0;
         end else begin
            prog_cnt <= prog_cnt + 32'h0000_0001;
         end
      end
   end

   // Storage is non-volatile in the real part, so it has no reset here.
   always_ff @(posedge core_clk) begin
      if (prog_done) begin
         for (int i = 0; i < PAGE_BYTES; i++) begin
            if (mask[i] && wr_fn == FN_MEM) begin
               mem[{wr_base[10:4], 4'(i)}] <= page_buf[i];
            end
            if (mask[i] && wr_fn == FN_ID) begin
               id_page[i] <= page_buf[i];
            end
         end
      end
   end

   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         id_lock <= 1'b0;
         soft_lock_bit <= 1'b0;
      end else if (prog_done && mask != '0) begin
         if (wr_fn == FN_LOCK) begin
            id_lock <= 1'b1;
         end
         if (wr_fn == FN_SOFT) begin
            soft_lock_bit <= page_buf[wr_base[3:0]][0];
         end
      end
   end
endmodule

//--- dv/eep_slave_port_assertions.sv
// Concurrent checks on the pins of the two-wire memory slave port.
module eep_slave_port_assertions #(
   parameter int unsigned PROG_CYCLES = 40
) (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic reset,
   // Watched pins.
   input wire logic scl,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic array_lock,
   input wire logic prog_busy
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned busy_cnt;
   default clocking @(posedge core_clk); endclocking
   default disable iff (reset);
   always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
         busy_cnt <= 0;
      end else if (prog_busy) begin
         busy_cnt <= busy_cnt + 1;
      end else begin
         busy_cnt <= 0;
      end
   end
   // Stop: clock high and data rising after a low stretch.
   sequence s_stop_seen;
      scl && sda_in && !$past(sda_in, 8);
   endsequence
   a_open_drain: assert property (sda_oe |-> sda_out == 1'b0)
      else $error("data pin driven high");
   a_oe_on_fall: assert property ($changed(sda_oe) |-> !scl && !$past(scl, 2))
      else $error("data output moved outside clock low");
   a_ack_whole: assert property ($rose(sda_oe) |-> sda_oe [*8])
      else $error("driven bit too short");
   a_busy_len: assert property ($fell(prog_busy) |-> busy_cnt == PROG_CYCLES)
      else $error("programming length wrong");
   a_busy_bound: assert property (busy_cnt <= PROG_CYCLES)
      else $error("programming too long");
   a_busy_stop: assert property ($rose(prog_busy) |-> s_stop_seen)
      else $error("programming began without stop");
   a_busy_no_ack: assert property (prog_busy |-> !$rose(sda_oe))
      else $error("answer while programming");
   a_lock_no_prog: assert property ($rose(prog_busy) |-> !array_lock)
      else $error("programming with lock pin high");
endmodule
bind eep_slave_port eep_slave_port_assertions #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
   .core_clk(core_clk), .reset(reset), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .array_lock(array_lock), .prog_busy(prog_busy));

//--- dv/eep_master_model.sv
// Bus master model that drives the two-wire link for the bench.
module eep_master_model (
   // Clock.
   input wire logic core_clk,
   // Link pins.
   input wire logic sda_wire,
   output logic scl,
   output logic sda_drv
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // Data moves two cycles after the clock fall, so it never races the edge.
   task automatic wait_n(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic bit_io(input logic b, output logic s);
      wait_n(2);
      sda_drv = b;
      wait_n(6);
      scl = 1'b1;
      wait_n(8);
      s = sda_wire;
      scl = 1'b0;
   endtask
   task automatic start();
      wait_n(2);
      sda_drv = 1'b1;
      wait_n(6);
      scl = 1'b1;
      wait_n(8);
      sda_drv = 1'b0;
      wait_n(8);
      scl = 1'b0;
   endtask
   task automatic stop();
      wait_n(2);
      sda_drv = 1'b0;
      wait_n(6);
      scl = 1'b1;
      wait_n(8);
      sda_drv = 1'b1;
      wait_n(8);
   endtask
   task automatic send(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(b[i], s);
      bit_io(1'b1, s);
      ack = (s === 1'b0);
   endtask
   task automatic recv(input logic mack, output logic [7:0] v);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         v[i] = s;
      end
      bit_io(~mack, s);
   endtask
endmodule

//--- dv/tb_serial_eeprom_slave_port.sv
// Self-checking bench for the two-wire memory slave port.
module tb_serial_eeprom_slave_port;
   timeunit 1ns;
   timeprecision 1ps;
   // Value is arbitrary.
   localparam logic [127:0] UID_TB = 128'hc35a_0f1e_2d3c_4b5a_6978_8796_a5b4_c3d2;
   typedef struct {
      logic [7:0] dev, word, data;
      logic lock, dack;
      logic [7:0] rexp, mask;
   } eep_row_s;
   eep_row_s rows [10] = '{
      '{8'hae, 8'hf3, 8'h5a, 1'b0, 1'b1, 8'h5a, 8'hff},
      '{8'hae, 8'hf3, 8'h33, 1'b1, 1'b0, 8'h5a, 8'hff},
      '{8'ha0, 8'h00, 8'ha5, 1'b0, 1'b1, 8'ha5, 8'hff},
      '{8'hb0, 8'h80, 8'h01, 1'b0, 1'b1, 8'h01, 8'h01},
      '{8'ha0, 8'h00, 8'h11, 1'b0, 1'b0, 8'ha5, 8'hff},
      '{8'hb0, 8'h80, 8'h00, 1'b0, 1'b1, 8'h00, 8'h01},
      '{8'hb0, 8'h03, 8'h3c, 1'b0, 1'b1, 8'h3c, 8'hff},
      '{8'hb0, 8'h40, 8'h00, 1'b0, 1'b1, 8'h01, 8'h01},
      '{8'hb0, 8'h03, 8'h99, 1'b0, 1'b0, 8'h3c, 8'hff},
      '{8'hb0, 8'hc0, 8'h00, 1'b0, 1'b0, UID_TB[127:120], 8'hff}};
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic array_lock = 1'b0;
   logic scl, sda_drv, sda_wire, sda_out, sda_oe, prog_busy, ak;
   logic [7:0] d;
   int mismatches = 0;
   int checks_done = 0;
   always #5 core_clk = ~core_clk;
   // Pull-up wire: low when either party pulls.
   assign sda_wire = sda_drv & ~sda_oe;
   eep_slave_port #(.PROG_CYCLES(400), .UID(UID_TB)) u_dut (
      .core_clk(core_clk), .reset(reset), .scl(scl), .sda_in(sda_wire),
      .sda_out(sda_out), .sda_oe(sda_oe), .array_lock(array_lock), .prog_busy(prog_busy));
   eep_master_model u_mst (.core_clk(core_clk), .sda_wire(sda_wire), .scl(scl),
      .sda_drv(sda_drv));
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d, mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic addr(input logic [7:0] dev, input logic [7:0] word);
      u_mst.start();
      u_mst.send(dev, ak);
      chk("device ack", 8'h01, 8'(ak));
      u_mst.send(word, ak);
      chk("word ack", 8'h01, 8'(ak));
   endtask
   task automatic rd(input logic [7:0] dev, input logic [7:0] word, output logic [7:0] v);
      addr(dev & 8'hfe, word);
      u_mst.start();
      u_mst.send(dev | 8'h01, ak);
      chk("read ack", 8'h01, 8'(ak));
      u_mst.recv(1'b0, v);
      chk("data out", 8'h00, 8'(sda_out));
      u_mst.stop();
   endtask
   task automatic idle();
      int n;
      n = 0;
      repeat (8) @(negedge core_clk);
      while (prog_busy !== 1'b0 && n < 2000) begin
         @(negedge core_clk);
         n++;
      end
      chk("busy end", 8'h00, 8'(prog_busy));
   endtask
   initial begin
      repeat (2) @(negedge core_clk);
      reset = 1'b0;
      chk("oe at reset", 8'h00, 8'(sda_oe));
      chk("busy at reset", 8'h00, 8'(prog_busy));
      repeat (3) @(negedge core_clk);
      foreach (rows[i]) begin
         array_lock = rows[i].lock;
         addr(rows[i].dev, rows[i].word);
         u_mst.send(rows[i].data, ak);
         u_mst.stop();
         chk("data ack", 8'(rows[i].dack), 8'(ak));
         chk("busy start", 8'(rows[i].dack), 8'(prog_busy));
         idle();
         array_lock = 1'b0;
         rd(rows[i].dev, rows[i].word, d);
         chk("read back", rows[i].rexp, d & rows[i].mask);
         $display("row %0d done", i);
      end
      // Partial page from offset 0x1e: the third byte lands at 0x10.
      addr(8'ha2, 8'h1e);
      for (int k = 0; k < 3; k++) begin
         u_mst.send(8'he1 + 8'(k), ak);
         chk("page ack", 8'h01, 8'(ak));
      end
      u_mst.stop();
      u_mst.start();
      u_mst.send(8'ha0, ak);
      u_mst.stop();
      chk("poll ack", 8'h00, 8'(ak));
      idle();
      rd(8'ha2, 8'h10, d);
      chk("wrapped byte", 8'he3, d);
      rd(8'ha2, 8'h1f, d);
      chk("page byte", 8'he2, d);
      $display("page and poll tests done");
      // A foreign type is refused and the next byte is ignored too.
      u_mst.start();
      u_mst.send(8'h90, ak);
      chk("foreign ack", 8'h00, 8'(ak));
      u_mst.send(8'ha0, ak);
      chk("ignored ack", 8'h00, 8'(ak));
      u_mst.stop();
      $display("foreign type test done");
      // A reset in mid-programming must drop busy and leave the array readable.
      addr(8'ha4, 8'h20);
      u_mst.send(8'h77, ak);
      u_mst.stop();
      chk("busy before reset", 8'h01, 8'(prog_busy));
      reset = 1'b1;
      repeat (2) @(negedge core_clk);
      reset = 1'b0;
      chk("busy after reset", 8'h00, 8'(prog_busy));
      chk("oe after reset", 8'h00, 8'(sda_oe));
      rd(8'ha0, 8'h00, d);
      chk("read after reset", 8'ha5, d);
      $display("reset test done");
      stop_test();
   end
   initial begin
      #500000;
      mismatches++;
      $display("unexpected watchdog: expected end, seen hang");
      stop_test();
   end
endmodule
